/* File: rtl/msp_pkg.sv */
`default_nettype none

package msp_pkg;

	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int CLK_HZ = 50_000_000;
	localparam int TICK_S = 1;
	localparam int TICK_CYCLES = TICK_S * CLK_HZ;

	// ---------------------------------------------------------------
	// register offsets
	// ---------------------------------------------------------------
	localparam logic [7:0] OFS_OC_CFG = 8'h00;
	localparam logic [7:0] OFS_UC_CFG = 8'h04;
	localparam logic [7:0] OFS_RATING = 8'h08;
	localparam logic [7:0] OFS_AUX = 8'h0C;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
	localparam logic [7:0] OFS_CTRL = 8'h1C;

	// ---------------------------------------------------------------
	// field positions
	// ---------------------------------------------------------------
	localparam int OC_LEVEL_LSB = 0;
	localparam int OC_TIME_LSB = 16;
	localparam int UC_LEVEL_LSB = 0;
	localparam int UC_TIME_LSB = 16;
	localparam int RAT_CUR_LSB = 0;
	localparam int RAT_VOLT_LSB = 4;
	localparam int RAT_DELTA_BIT = 8;
	localparam int RAT_PHASE_BIT = 9;
	localparam int RAT_BRAKE_BIT = 10;
	localparam int AUX_JOG_LSB = 0;
	localparam int AUX_ACCEL_LSB = 8;
	localparam int AUX_DECEL_LSB = 16;
	localparam int AUX_BRAKE_LSB = 24;
	localparam int CTRL_CLR_BIT = 0;

	// ---------------------------------------------------------------
	// limits and reset values
	// ---------------------------------------------------------------
	localparam logic [8:0] OC_LEVEL_RST = 9'h096;
	localparam logic [7:0] OC_TIME_MAX = 8'h14;
	localparam logic [7:0] UC_LEVEL_MIN = 8'h14;
	localparam logic [7:0] UC_LEVEL_MAX = 8'hBE;
	localparam logic [7:0] UC_LEVEL_RST = 8'h46;
	localparam logic [7:0] UC_TIME_MAX = 8'hC8;
	localparam logic [7:0] JOG_MIN = 8'h19;
	localparam logic [7:0] JOG_MAX = 8'h32;
	localparam logic [7:0] JOG_RST = 8'h19;
	localparam logic [7:0] ACCEL_MIN = 8'h01;
	localparam logic [7:0] ACCEL_MAX = 8'hF0;
	localparam logic [7:0] ACCEL_RST = 8'h14;
	localparam logic [7:0] BRAKE_TIME_MAX = 8'h0A;
	localparam logic [7:0] TIME_OFF = 8'h00;
	localparam logic [3:0] CUR_IDX_MAX = 4'hD;
	localparam logic [3:0] VOLT_IDX_MAX = 4'hA;
	localparam logic [3:0] VOLT_IDX_RST = 4'h3;
	localparam logic [19:0] DELTA_NUM = 20'h000AD;
	localparam logic [19:0] DELTA_DEN = 20'h00064;

	localparam logic [10:0] RATED_AMPS [14] = '{11'h078, 11'h0AA, 11'h0CD, 11'h0FF,
		11'h122, 11'h154, 11'h19A, 11'h1DB, 11'h244, 11'h29E, 11'h320, 11'h3B6,
		11'h44C, 11'h578};
	localparam logic [9:0] RATED_VOLTS [11] = '{10'h0DC, 10'h0E6, 10'h0F0, 10'h17C,
		10'h190, 10'h19F, 10'h1B8, 10'h1CC, 10'h1E0, 10'h20D, 10'h23F};

	// ---------------------------------------------------------------
	// fault codes and interrupt bits
	// ---------------------------------------------------------------
	localparam logic [3:0] FLT_NONE = 4'h0;
	localparam logic [3:0] FLT_JOG = 4'h2;
	localparam logic [3:0] FLT_OC = 4'h6;
	localparam logic [3:0] FLT_UC = 4'h7;
	localparam logic [3:0] FLT_PHASE = 4'h8;
	localparam int IRQ_W = 4;
	localparam int IRQ_OC = 0;
	localparam int IRQ_UC = 1;
	localparam int IRQ_JOG = 2;
	localparam int IRQ_PHASE = 3;

	typedef enum logic [1:0] {
		MD_IDLE = 2'b00,
		MD_RUN = 2'b01,
		MD_JOG = 2'b10,
		MD_BRAKE = 2'b11
	} msp_mode_e;

endpackage

`default_nettype wire

/* File: rtl/msp_run_protect.sv */
`timescale 1ns/100ps
`default_nettype none

module msp_run_protect #(
	parameter int TICK_CYCLES = msp_pkg::TICK_CYCLES,
	parameter logic [3:0] CUR_IDX_RST = 4'h0
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [8:0] cur_pct,
	input wire logic full_voltage,
	input wire logic run_request,
	input wire logic power_on,
	input wire logic jog_input,
	input wire logic phase_seq_fwd,
	output logic drive_enable,
	output logic jog_active,
	output logic [7:0] jog_level,
	output logic jog_decel,
	output logic dc_brake,
	output logic thermal_hold,
	output logic [11:0] rated_ref_amps,
	output logic [9:0] rated_volt,
	output logic [3:0] fault_code,
	output logic irq
);

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	function automatic logic [7:0] clamp8(input logic [7:0] v, input logic [7:0] lo,
		input logic [7:0] hi);
		logic [7:0] r;
		r = v;
		if (v < lo) begin
			r = lo;
		end else if (v > hi) begin
			r = hi;
		end
		return r;
	endfunction

	logic tick;
	msp_tick #(.TICK_CYCLES(TICK_CYCLES)) msp_tick_i (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.tick(tick)
	);

	// ---------------------------------------------------------------
	// pin synchronisers
	// ---------------------------------------------------------------
	logic [1:0] sync1_q, sync2_q;
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			sync1_q <= 2'h0;
			sync2_q <= 2'h0;
		end else begin
			sync1_q <= {phase_seq_fwd, jog_input};
			sync2_q <= sync1_q;
		end
	end
	logic jog_s, seq_s;
	assign jog_s = sync2_q[0];
	assign seq_s = sync2_q[1];

	// ---------------------------------------------------------------
	// configuration and apb
	// ---------------------------------------------------------------
	logic [8:0] oc_level_q, oc_level_d;
	logic [7:0] oc_time_q, oc_time_d, uc_level_q, uc_level_d, uc_time_q, uc_time_d;
	logic [3:0] cur_idx_q, cur_idx_d, volt_idx_q, volt_idx_d;
	logic delta_q, delta_d, phase_chk_q, phase_chk_d, brake_sel_q, brake_sel_d;
	logic [7:0] jog_v_q, jog_v_d, accel_q, accel_d, decel_q, decel_d, brk_t_q, brk_t_d;
	localparam int IRQ_W_L = msp_pkg::IRQ_W;
	logic [IRQ_W_L-1:0] stat_q, stat_d, mask_q, mask_d, events;
	logic fault_clr;
	logic [31:0] prdata_q, prdata_d;
	logic pready_q, pready_d, pslverr_q, pslverr_d;
	logic wr_en;
	logic [31:0] rd_val;
	logic hit;

	// status words filled by the protection group
	logic [11:0] ref_q;
	logic [3:0] fault_q, code_q;
	msp_pkg::msp_mode_e mode_q;
	logic locked_q, seq_ok_q;

	always_comb begin
		wr_en = psel && penable && pwrite && pready_q;
		oc_level_d = oc_level_q;
		oc_time_d = oc_time_q;
		uc_level_d = uc_level_q;
		uc_time_d = uc_time_q;
		cur_idx_d = cur_idx_q;
		volt_idx_d = volt_idx_q;
		delta_d = delta_q;
		phase_chk_d = phase_chk_q;
		brake_sel_d = brake_sel_q;
		jog_v_d = jog_v_q;
		accel_d = accel_q;
		decel_d = decel_q;
		brk_t_d = brk_t_q;
		mask_d = mask_q;
		fault_clr = 1'b0;
		// set wins over write-one-to-clear
		stat_d = stat_q | events;
		hit = 1'b1;
		rd_val = 32'h0000_0000;
		unique case (paddr)
			msp_pkg::OFS_OC_CFG: rd_val = {8'h00, oc_time_q, 7'h00, oc_level_q};
			msp_pkg::OFS_UC_CFG: rd_val = {8'h00, uc_time_q, 8'h00, uc_level_q};
			msp_pkg::OFS_RATING: rd_val = {21'h0, brake_sel_q, phase_chk_q, delta_q,
				volt_idx_q, cur_idx_q};
			msp_pkg::OFS_AUX: rd_val = {brk_t_q, decel_q, accel_q, jog_v_q};
			msp_pkg::OFS_STATUS: rd_val = {12'h000, seq_ok_q, locked_q, mode_q, fault_q, ref_q};
			msp_pkg::OFS_IRQ_STAT: rd_val = {28'h0, stat_q};
			msp_pkg::OFS_IRQ_MASK: rd_val = {28'h0, mask_q};
			msp_pkg::OFS_CTRL: rd_val = 32'h0000_0000;
			default: hit = 1'b0;
		endcase
		if (wr_en && hit) begin
			unique case (paddr)
				msp_pkg::OFS_OC_CFG: begin
					oc_level_d = pwdata[msp_pkg::OC_LEVEL_LSB +: 9];
					oc_time_d = (pwdata[msp_pkg::OC_TIME_LSB +: 8] == msp_pkg::TIME_OFF) ?
						msp_pkg::TIME_OFF : clamp8(pwdata[msp_pkg::OC_TIME_LSB +: 8],
						8'h01, msp_pkg::OC_TIME_MAX);
				end
				msp_pkg::OFS_UC_CFG: begin
					uc_level_d = clamp8(pwdata[msp_pkg::UC_LEVEL_LSB +: 8], msp_pkg::UC_LEVEL_MIN,
						msp_pkg::UC_LEVEL_MAX);
					uc_time_d = (pwdata[msp_pkg::UC_TIME_LSB +: 8] == msp_pkg::TIME_OFF) ?
						msp_pkg::TIME_OFF : clamp8(pwdata[msp_pkg::UC_TIME_LSB +: 8],
						8'h01, msp_pkg::UC_TIME_MAX);
				end
				msp_pkg::OFS_RATING: begin
					cur_idx_d = (pwdata[msp_pkg::RAT_CUR_LSB +: 4] > msp_pkg::CUR_IDX_MAX) ?
						msp_pkg::CUR_IDX_MAX : pwdata[msp_pkg::RAT_CUR_LSB +: 4];
					volt_idx_d = (pwdata[msp_pkg::RAT_VOLT_LSB +: 4] > msp_pkg::VOLT_IDX_MAX) ?
						msp_pkg::VOLT_IDX_MAX : pwdata[msp_pkg::RAT_VOLT_LSB +: 4];
					delta_d = pwdata[msp_pkg::RAT_DELTA_BIT];
					phase_chk_d = pwdata[msp_pkg::RAT_PHASE_BIT];
					brake_sel_d = pwdata[msp_pkg::RAT_BRAKE_BIT];
				end
				msp_pkg::OFS_AUX: begin
					jog_v_d = clamp8(pwdata[msp_pkg::AUX_JOG_LSB +: 8], msp_pkg::JOG_MIN,
						msp_pkg::JOG_MAX);
					accel_d = clamp8(pwdata[msp_pkg::AUX_ACCEL_LSB +: 8], msp_pkg::ACCEL_MIN,
						msp_pkg::ACCEL_MAX);
					decel_d = pwdata[msp_pkg::AUX_DECEL_LSB +: 8];
					brk_t_d = (pwdata[msp_pkg::AUX_BRAKE_LSB +: 8] > msp_pkg::BRAKE_TIME_MAX) ?
						msp_pkg::BRAKE_TIME_MAX : pwdata[msp_pkg::AUX_BRAKE_LSB +: 8];
				end
				msp_pkg::OFS_IRQ_STAT: stat_d = (stat_q & ~pwdata[IRQ_W_L-1:0]) | events;
				msp_pkg::OFS_IRQ_MASK: mask_d = pwdata[IRQ_W_L-1:0];
				msp_pkg::OFS_CTRL: fault_clr = pwdata[msp_pkg::CTRL_CLR_BIT];
				default: fault_clr = 1'b0;
			endcase
		end
		pready_d = psel && !penable;
		pslverr_d = psel && !penable && !hit;
		prdata_d = (psel && !penable && !pwrite) ? rd_val : prdata_q;
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			oc_level_q <= msp_pkg::OC_LEVEL_RST;
			oc_time_q <= msp_pkg::TIME_OFF;
			uc_level_q <= msp_pkg::UC_LEVEL_RST;
			uc_time_q <= msp_pkg::TIME_OFF;
			cur_idx_q <= CUR_IDX_RST;
			volt_idx_q <= msp_pkg::VOLT_IDX_RST;
			delta_q <= 1'b0;
			phase_chk_q <= 1'b0;
			brake_sel_q <= 1'b0;
			jog_v_q <= msp_pkg::JOG_RST;
			accel_q <= msp_pkg::ACCEL_RST;
			decel_q <= msp_pkg::TIME_OFF;
			brk_t_q <= msp_pkg::TIME_OFF;
			stat_q <= '0;
			mask_q <= '0;
			prdata_q <= 32'h0000_0000;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			oc_level_q <= oc_level_d;
			oc_time_q <= oc_time_d;
			uc_level_q <= uc_level_d;
			uc_time_q <= uc_time_d;
			cur_idx_q <= cur_idx_d;
			volt_idx_q <= volt_idx_d;
			delta_q <= delta_d;
			phase_chk_q <= phase_chk_d;
			brake_sel_q <= brake_sel_d;
			jog_v_q <= jog_v_d;
			accel_q <= accel_d;
			decel_q <= decel_d;
			brk_t_q <= brk_t_d;
			stat_q <= stat_d;
			mask_q <= mask_d;
			prdata_q <= prdata_d;
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
		end
	end

	// ---------------------------------------------------------------
	// protection, jog, braking
	// ---------------------------------------------------------------
	msp_pkg::msp_mode_e mode_d;
	logic [7:0] oc_cnt_q, oc_cnt_d, uc_cnt_q, uc_cnt_d, tm_q, tm_d;
	logic [11:0] ref_d;
	logic [3:0] fault_d, code_d, new_fault;
	logic locked_d, seq_ok_d, pwr_prev_q;
	logic armed, oc_cond, uc_cond, oc_trip, uc_trip, jog_to, brk_end, brake_ok;
	logic phase_refuse, lock_now;
	logic drv_q, drv_d, jog_q, jog_d, decel_q2, decel_d2, brk_q, brk_d, irq_q, irq_d;
	logic [9:0] volt_q, volt_d;

	always_comb begin
		ref_d = 12'(msp_pkg::RATED_AMPS[cur_idx_q]);
		if (delta_q) begin
			ref_d = 12'((20'(msp_pkg::RATED_AMPS[cur_idx_q]) * msp_pkg::DELTA_NUM) /
				msp_pkg::DELTA_DEN);
		end
		volt_d = msp_pkg::RATED_VOLTS[volt_idx_q];
		// armed only at full voltage run
		armed = (mode_q == msp_pkg::MD_RUN) && full_voltage;
		oc_cond = armed && (oc_time_q != msp_pkg::TIME_OFF) && (cur_pct > oc_level_q);
		uc_cond = armed && (uc_time_q != msp_pkg::TIME_OFF) && (cur_pct < {1'b0, uc_level_q});
		// second counters clear on condition loss
		oc_cnt_d = oc_cond ? (tick ? oc_cnt_q + 8'h01 : oc_cnt_q) : 8'h00;
		uc_cnt_d = uc_cond ? (tick ? uc_cnt_q + 8'h01 : uc_cnt_q) : 8'h00;
		oc_trip = oc_cond && tick && (oc_cnt_q == oc_time_q);
		uc_trip = uc_cond && tick && (uc_cnt_q == uc_time_q);
		jog_to = (mode_q == msp_pkg::MD_JOG) && tick && (tm_q == accel_q);
		brk_end = (mode_q == msp_pkg::MD_BRAKE) && tick && (tm_q == brk_t_q);
		brake_ok = brake_sel_q && !delta_q && (brk_t_q != msp_pkg::TIME_OFF);
		lock_now = power_on && !pwr_prev_q && !locked_q;
		locked_d = locked_q || lock_now;
		seq_ok_d = lock_now ? seq_s : seq_ok_q;
		phase_refuse = phase_chk_q && locked_q && !seq_ok_q;
		new_fault = oc_trip ? msp_pkg::FLT_OC : uc_trip ? msp_pkg::FLT_UC :
			jog_to ? msp_pkg::FLT_JOG : msp_pkg::FLT_NONE;
		// a new trip beats a clear in the same cycle
		fault_d = (new_fault != msp_pkg::FLT_NONE) ? new_fault :
			(fault_clr ? msp_pkg::FLT_NONE : fault_q);
		mode_d = mode_q;
		unique case (mode_q)
			msp_pkg::MD_IDLE: begin
				if (fault_q == msp_pkg::FLT_NONE && !phase_refuse) begin
					if (jog_s) begin
						mode_d = msp_pkg::MD_JOG;
					end else if (run_request) begin
						mode_d = msp_pkg::MD_RUN;
					end
				end
			end
			msp_pkg::MD_RUN: begin
				if (oc_trip || uc_trip || phase_refuse) begin
					mode_d = msp_pkg::MD_IDLE;
				end else if (!run_request) begin
					mode_d = brake_ok ? msp_pkg::MD_BRAKE : msp_pkg::MD_IDLE;
				end
			end
			msp_pkg::MD_JOG: begin
				if (jog_to || !jog_s || phase_refuse) begin
					mode_d = msp_pkg::MD_IDLE;
				end
			end
			msp_pkg::MD_BRAKE: begin
				if (brk_end) begin
					mode_d = msp_pkg::MD_IDLE;
				end
			end
		endcase
		tm_d = (mode_d != mode_q) ? 8'h00 : (tick ? tm_q + 8'h01 : tm_q);
		drv_d = (mode_d == msp_pkg::MD_RUN) || (mode_d == msp_pkg::MD_JOG);
		jog_d = (mode_d == msp_pkg::MD_JOG);
		// ramp down after jog if decel set
		decel_d2 = (mode_q == msp_pkg::MD_JOG) && !jog_s && (decel_q != msp_pkg::TIME_OFF);
		brk_d = (mode_d == msp_pkg::MD_BRAKE);
		code_d = (fault_d != msp_pkg::FLT_NONE) ? fault_d :
			(phase_refuse ? msp_pkg::FLT_PHASE : msp_pkg::FLT_NONE);
		events = '0;
		events[msp_pkg::IRQ_OC] = oc_trip;
		events[msp_pkg::IRQ_UC] = uc_trip;
		events[msp_pkg::IRQ_JOG] = jog_to;
		events[msp_pkg::IRQ_PHASE] = lock_now && phase_chk_q && !seq_s;
		irq_d = |(stat_d & mask_q);
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			mode_q <= msp_pkg::MD_IDLE;
			oc_cnt_q <= 8'h00;
			uc_cnt_q <= 8'h00;
			tm_q <= 8'h00;
			ref_q <= 12'h000;
			volt_q <= 10'h000;
			fault_q <= msp_pkg::FLT_NONE;
			code_q <= msp_pkg::FLT_NONE;
			locked_q <= 1'b0;
			seq_ok_q <= 1'b0;
			pwr_prev_q <= 1'b0;
			drv_q <= 1'b0;
			jog_q <= 1'b0;
			decel_q2 <= 1'b0;
			brk_q <= 1'b0;
			irq_q <= 1'b0;
		end else begin
			mode_q <= mode_d;
			oc_cnt_q <= oc_cnt_d;
			uc_cnt_q <= uc_cnt_d;
			tm_q <= tm_d;
			ref_q <= ref_d;
			volt_q <= volt_d;
			fault_q <= fault_d;
			code_q <= code_d;
			locked_q <= locked_d;
			seq_ok_q <= seq_ok_d;
			pwr_prev_q <= power_on;
			drv_q <= drv_d;
			jog_q <= jog_d;
			decel_q2 <= decel_d2;
			brk_q <= brk_d;
			irq_q <= irq_d;
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign drive_enable = drv_q;
	assign jog_active = jog_q;
	assign jog_level = jog_v_q;
	assign jog_decel = decel_q2;
	assign dc_brake = brk_q;
	assign thermal_hold = brk_q;
	assign rated_ref_amps = ref_q;
	assign rated_volt = volt_q;
	assign fault_code = code_q;
	assign irq = irq_q;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	sequence oc_fire_s;
		oc_cond && tick && (oc_cnt_q == oc_time_q);
	endsequence
	sequence off_next_s;
		!drive_enable && (fault_code == msp_pkg::FLT_OC);
	endsequence

	oc_trip_off_a: assert property (oc_fire_s |=> off_next_s)
		else $error("overcurrent trip did not stop output");
	oc_arm_run_a: assert property (!armed |=> oc_cnt_q == 8'h00)
		else $error("overcurrent timer ran while not armed");
	oc_time_off_a: assert property (oc_time_q == msp_pkg::TIME_OFF |-> !oc_trip)
		else $error("overcurrent tripped while off");
	uc_trip_code_a: assert property (uc_trip && !oc_trip |=> fault_code == msp_pkg::FLT_UC)
		else $error("undercurrent trip not reported");
	uc_level_range_a: assert property (uc_level_q >= msp_pkg::UC_LEVEL_MIN
		&& uc_level_q <= msp_pkg::UC_LEVEL_MAX)
		else $error("undercurrent level out of range");
	jog_timeout_a: assert property (jog_to |=> (fault_q == msp_pkg::FLT_JOG) && !jog_active)
		else $error("jog timeout not handled");
	brake_no_delta_a: assert property ($rose(mode_q == msp_pkg::MD_BRAKE) |-> !$past(delta_q))
		else $error("braking entered with inside delta");
	brake_thermal_a: assert property (mode_q == msp_pkg::MD_BRAKE |-> thermal_hold)
		else $error("thermal hold missing during brake");
	phase_once_a: assert property (locked_q |=> locked_q && $stable(seq_ok_q))
		else $error("phase sequence resampled");
	phase_refuse_a: assert property (phase_refuse |-> ##2 !drive_enable)
		else $error("drive on wrong phase sequence");

endmodule // msp_run_protect

`default_nettype wire

/* File: rtl/msp_tick.sv */
`timescale 1ns/100ps
`default_nettype none

module msp_tick #(
	parameter int TICK_CYCLES = msp_pkg::TICK_CYCLES
) (
	input wire logic ref_clk,
	input wire logic resetn,
	output logic tick
);

	logic [31:0] cnt_q, cnt_d;
	logic tick_q, tick_d;

	always_comb begin
		tick_d = (cnt_q == 32'(TICK_CYCLES - 1));
		cnt_d = tick_d ? 32'h0000_0000 : cnt_q + 32'h0000_0001;
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			cnt_q <= 32'h0000_0000;
			tick_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			tick_q <= tick_d;
		end
	end

	assign tick = tick_q;

endmodule // msp_tick

`default_nettype wire

/* File: verification/motor_starter_run_protection_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none

module motor_starter_run_protection_tb_top;
	logic ref_clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, slv;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, full_voltage, phase_seq_fwd, drive_enable, jog_active;
	logic run_request = 0, power_on = 0, jog_input = 0, fwd = 1, hold = 0;
	logic [8:0] cur_pct, load = 9'h064;
	logic [7:0] jog_level;
	logic jog_decel, dc_brake, thermal_hold, irq;
	logic [11:0] rated_ref_amps;
	logic [9:0] rated_volt;
	logic [3:0] fault_code;
	int err_total = 0, check_count = 0, cyc = 0, n;

	msp_run_protect #(.TICK_CYCLES(10)) msp_run_protect_i (.ref_clk(ref_clk), .resetn(resetn),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .cur_pct(cur_pct),
		.full_voltage(full_voltage), .run_request(run_request), .power_on(power_on),
		.jog_input(jog_input), .phase_seq_fwd(phase_seq_fwd), .drive_enable(drive_enable),
		.jog_active(jog_active), .jog_level(jog_level), .jog_decel(jog_decel),
		.dc_brake(dc_brake), .thermal_hold(thermal_hold), .rated_ref_amps(rated_ref_amps),
		.rated_volt(rated_volt), .fault_code(fault_code), .irq(irq));
	msp_motor_model msp_motor_model_i (.ref_clk(ref_clk), .resetn(resetn),
		.drive_enable(drive_enable), .hold_accel(hold), .load_pct(load), .seq_fwd_in(fwd),
		.cur_pct(cur_pct), .full_voltage(full_voltage), .phase_seq_fwd(phase_seq_fwd));

	initial begin
		forever #10 ref_clk = ~ref_clk;
	end

	task automatic complete_run;
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 6000) begin
			err_total++;
			complete_run();
		end
	end

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			err_total++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge ref_clk);
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		psel <= 1'b1;
		penable <= 1'b0;
		@(posedge ref_clk);
		penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		rd = prdata;
		slv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(a, 1'b1, d);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		apb(a, 1'b0, 32'h0);
		chk("register", e, rd);
	endtask

	task automatic wt(input int c);
		repeat (c) @(posedge ref_clk);
	endtask

	task automatic wait_fault(input logic [3:0] c);
		n = 0;
		while (fault_code !== c && n < 300) begin
			@(posedge ref_clk);
			n++;
		end
		chk("fault_code", c, fault_code);
	endtask

	task automatic clear_all;
		run_request <= 1'b0;
		wr(msp_pkg::OFS_IRQ_STAT, 32'h0000000F);
		wr(msp_pkg::OFS_CTRL, 32'h00000001);
		wt(2);
		chk("irq", 1'b0, irq);
		chk("fault_code", 4'h0, fault_code);
	endtask

	task automatic done(input string nm);
		$display("test %s finished, mismatches so far %0d", nm, err_total);
	endtask

	initial begin
		wt(5);
		resetn <= 1'b1;
		// let the sequence synchroniser fill before the first activation
		wt(3);
		power_on <= 1'b1;
		rdc(msp_pkg::OFS_OC_CFG, 32'h00000096);
		rdc(msp_pkg::OFS_UC_CFG, 32'h00000046);
		rdc(msp_pkg::OFS_AUX, 32'h00001419);
		chk("rated_volt", 10'h17C, rated_volt);
		chk("rated_ref_amps", 12'h078, rated_ref_amps);
		apb(8'h20, 1'b0, 32'h0);
		chk("pslverr", 1'b1, slv);
		wr(msp_pkg::OFS_OC_CFG, 32'h00FF0096);
		rdc(msp_pkg::OFS_OC_CFG, 32'h00140096);
		wr(msp_pkg::OFS_UC_CFG, 32'h00FF00FF);
		rdc(msp_pkg::OFS_UC_CFG, 32'h00C800BE);
		wr(msp_pkg::OFS_UC_CFG, 32'h00000005);
		rdc(msp_pkg::OFS_UC_CFG, 32'h00000014);
		wr(msp_pkg::OFS_UC_CFG, 32'h00000046);
		wr(msp_pkg::OFS_RATING, 32'h000000AD);
		wt(2);
		chk("rated_ref_amps", 12'h578, rated_ref_amps);
		chk("rated_volt", 10'h23F, rated_volt);
		wr(msp_pkg::OFS_RATING, 32'h00000030);
		done("settings");
		wr(msp_pkg::OFS_IRQ_MASK, 32'h0000000F);
		wr(msp_pkg::OFS_OC_CFG, 32'h00020096);
		load <= 9'h0C8;
		hold <= 1'b1;
		run_request <= 1'b1;
		wt(60);
		chk("fault_code", 4'h0, fault_code);
		chk("drive_enable", 1'b1, drive_enable);
		hold <= 1'b0;
		wait_fault(msp_pkg::FLT_OC);
		chk("oc_delay", 1'b1, n >= 20 && n <= 45);
		chk("drive_enable", 1'b0, drive_enable);
		chk("irq", 1'b1, irq);
		rdc(msp_pkg::OFS_IRQ_STAT, 32'h00000001);
		clear_all();
		wr(msp_pkg::OFS_OC_CFG, 32'h00000096);
		run_request <= 1'b1;
		wt(80);
		chk("fault_code", 4'h0, fault_code);
		done("overcurrent");
		wr(msp_pkg::OFS_UC_CFG, 32'h00010046);
		load <= 9'h00A;
		wait_fault(msp_pkg::FLT_UC);
		chk("uc_delay", 1'b1, n >= 10 && n <= 35);
		rdc(msp_pkg::OFS_IRQ_STAT, 32'h00000002);
		clear_all();
		wr(msp_pkg::OFS_UC_CFG, 32'h00000046);
		load <= 9'h064;
		done("undercurrent");
		fwd <= 1'b0;
		wr(msp_pkg::OFS_RATING, 32'h00000630);
		wr(msp_pkg::OFS_AUX, 32'h02001419);
		run_request <= 1'b1;
		wt(20);
		chk("drive_enable", 1'b1, drive_enable);
		run_request <= 1'b0;
		wt(5);
		chk("dc_brake", 1'b1, dc_brake);
		chk("thermal_hold", 1'b1, thermal_hold);
		n = 0;
		while (dc_brake === 1'b1 && n < 60) begin
			@(posedge ref_clk);
			n++;
		end
		chk("brake_len", 1'b1, n >= 12 && n <= 35);
		wr(msp_pkg::OFS_RATING, 32'h00000731);
		wt(2);
		chk("rated_ref_amps", 12'h126, rated_ref_amps);
		run_request <= 1'b1;
		wt(20);
		run_request <= 1'b0;
		n = 0;
		repeat (40) begin
			@(posedge ref_clk);
			if (dc_brake !== 1'b0) n++;
		end
		chk("delta_brake", 32'h0, n);
		wr(msp_pkg::OFS_RATING, 32'h00000030);
		done("braking");
		wr(msp_pkg::OFS_AUX, 32'h00010528);
		jog_input <= 1'b1;
		wt(8);
		chk("jog_active", 1'b1, jog_active);
		chk("jog_level", 8'h28, jog_level);
		jog_input <= 1'b0;
		n = 0;
		while (jog_decel !== 1'b1 && n < 10) begin
			@(posedge ref_clk);
			n++;
		end
		chk("jog_decel", 1'b1, jog_decel);
		wt(10);
		wr(msp_pkg::OFS_AUX, 32'h00000228);
		jog_input <= 1'b1;
		wait_fault(msp_pkg::FLT_JOG);
		chk("jog_len", 1'b1, n >= 15 && n <= 45);
		chk("drive_enable", 1'b0, drive_enable);
		jog_input <= 1'b0;
		clear_all();
		done("jog");
		power_on <= 1'b0;
		resetn <= 1'b0;
		wt(5);
		resetn <= 1'b1;
		wr(msp_pkg::OFS_RATING, 32'h00000230);
		wt(4);
		power_on <= 1'b1;
		wait_fault(msp_pkg::FLT_PHASE);
		rdc(msp_pkg::OFS_IRQ_STAT, 32'h00000008);
		run_request <= 1'b1;
		wt(20);
		chk("drive_enable", 1'b0, drive_enable);
		done("phase");
		complete_run();
	end
endmodule // motor_starter_run_protection_tb_top

`default_nettype wire

/* File: verification/msp_motor_model.sv */
`timescale 1ns/100ps
`default_nettype none

// ---------------------------------------------------------------
// motor and line model
// ---------------------------------------------------------------
module msp_motor_model (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic drive_enable,
	input wire logic hold_accel,
	input wire logic [8:0] load_pct,
	input wire logic seq_fwd_in,
	output logic [8:0] cur_pct,
	output logic full_voltage,
	output logic phase_seq_fwd
);
	logic [1:0] ramp_q;
	logic [1:0] ramp_d;

	// current flows only while driven
	always_comb begin
		ramp_d = drive_enable ? ((ramp_q == 2'h3) ? ramp_q : ramp_q + 2'h1) : 2'h0;
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			ramp_q <= 2'h0;
		end else begin
			ramp_q <= ramp_d;
		end
	end

	assign cur_pct = drive_enable ? load_pct : 9'h000;
	assign full_voltage = drive_enable && (ramp_q == 2'h3) && !hold_accel;
	assign phase_seq_fwd = seq_fwd_in;
endmodule // msp_motor_model

`default_nettype wire
